//--- lda_controller.sv
`timescale 1ns/1ps
module lda_controller #(
  parameter int HIGH_CYC = lda_pkg::RST_HIGH_CYC,
  parameter int LOW_CYC  = 16
) (
  input  wire logic                      CLK_SYS_I,
  input  wire logic                      NRST_I,
  input  wire logic                      CE_I,
  input  wire logic                      ENABLE_I,
  input  wire logic                      GAIN_HIGH_I,
  input  wire logic                      PITCH_FINE_I,
  input  wire logic                      SLAVE_I,
  input  wire logic                      START_IN_N_I,
  output logic [lda_pkg::PIX_W-1:0]      PIX_DATA_O,
  output logic                           PIX_VALID_O,
  input  wire logic                      PIX_READY_I,
  output logic                           LINE_DONE_O,
  lda_if.ctl                             LINK
);
  typedef enum logic [1:0] {
    LDC_IDLE = 2'b00,
    LDC_HIGH = 2'b01,
    LDC_LOW  = 2'b10,
    LDC_READ = 2'b11
  } ldc_state_type;

  ldc_state_type             st_r;
  logic [lda_pkg::CNT_W-1:0] cnt_r;
  logic [lda_pkg::CNT_W-1:0] got_r;
  logic [lda_pkg::CNT_W-1:0] npix_r;
  logic [1:0]                eos_s_r;
  logic [1:0]                vv_s_r;
  logic [lda_pkg::PIX_W-1:0] vd_s0_r;
  logic [lda_pkg::PIX_W-1:0] vd_s1_r;
  logic                      vv_d_r;
  logic                      take;
  logic                      fifo_ready;
  logic [lda_pkg::PIX_W-1:0] fifo_data;
  logic                      fifo_valid;

  // ----------------------------------------------------------------
  // Link input synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS_I) begin
    if (!NRST_I) begin
      eos_s_r <= 2'b11;
      vv_s_r  <= 2'b00;
      vd_s0_r <= '0;
      vd_s1_r <= '0;
      vv_d_r  <= 1'b0;
    end else if (CE_I) begin
      eos_s_r <= {eos_s_r[0], LINK.scan_done_pulse_n};
      vv_s_r  <= {vv_s_r[0], LINK.video_valid};
      vd_s0_r <= LINK.video;
      vd_s1_r <= vd_s0_r;
      vv_d_r  <= vv_s_r[1];
    end
  end

  assign take = vv_s_r[1] && !vv_d_r && (st_r == LDC_READ) && (got_r < npix_r);

  // ----------------------------------------------------------------
  // Line reset generator
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS_I) begin
    if (!NRST_I) begin
      st_r                   <= LDC_IDLE;
      cnt_r                  <= '0;
      got_r                  <= '0;
      npix_r                 <= '0;
      LINE_DONE_O            <= 1'b0;
      LINK.line_reset_n      <= 1'b1;
      LINK.gain_select       <= 1'b0;
      LINK.pitch_select      <= 1'b0;
      LINK.chain_role_select <= 1'b1;
      LINK.chain_start_in_n  <= 1'b1;
    end else if (CE_I) begin
      LINE_DONE_O            <= 1'b0;
      LINK.gain_select       <= GAIN_HIGH_I;
      LINK.pitch_select      <= PITCH_FINE_I;
      LINK.chain_role_select <= !SLAVE_I;
      LINK.chain_start_in_n  <= START_IN_N_I;
      if (take) begin
        got_r <= got_r + 1'b1;
      end
      unique case (st_r)
        LDC_IDLE: begin
          if (ENABLE_I) begin
            st_r              <= LDC_HIGH;
            cnt_r             <= '0;
            LINK.line_reset_n <= 1'b1;
          end
        end
        LDC_HIGH: begin
          cnt_r <= cnt_r + 1'b1;
          if (cnt_r >= lda_pkg::CNT_W'(HIGH_CYC - 1)) begin
            st_r              <= LDC_LOW;
            cnt_r             <= '0;
            got_r             <= '0;
            npix_r            <= lda_pkg::pix_count(PITCH_FINE_I);
            LINK.line_reset_n <= 1'b0;
          end
        end
        LDC_LOW: begin
          cnt_r <= cnt_r + 1'b1;
          if (cnt_r >= lda_pkg::CNT_W'(LOW_CYC - 1)) begin
            st_r              <= LDC_READ;
            LINK.line_reset_n <= 1'b1;
          end
        end
        LDC_READ: begin
          // Next line waits for last pixel, keeping reset quiet meanwhile
          if (eos_s_r[1] && got_r == npix_r && !take) begin
            LINE_DONE_O <= 1'b1;
            st_r        <= ENABLE_I ? LDC_HIGH : LDC_IDLE;
            cnt_r       <= '0;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pixel buffer
  // ----------------------------------------------------------------
  lda_fifo #(
    .WIDTH (lda_pkg::PIX_W),
    .DEPTH (16)
  ) u_fifo (
    .clk_i       (CLK_SYS_I),
    .nrst_i      (NRST_I),
    .ce_i        (CE_I),
    .in_data_i   (vd_s1_r),
    .in_valid_i  (take),
    .in_ready_o  (fifo_ready),
    .out_data_o  (fifo_data),
    .out_valid_o (fifo_valid),
    .out_ready_i (PIX_READY_I && !PIX_VALID_O)
  );

  always_ff @(posedge CLK_SYS_I) begin
    if (!NRST_I) begin
      PIX_DATA_O  <= '0;
      PIX_VALID_O <= 1'b0;
    end else if (CE_I) begin
      if (PIX_VALID_O && PIX_READY_I) begin
        PIX_VALID_O <= 1'b0;
      end else if (!PIX_VALID_O && fifo_valid && PIX_READY_I) begin
        PIX_DATA_O  <= fifo_data;
        PIX_VALID_O <= 1'b1;
      end
    end
  end

  logic unused_ready;
  assign unused_ready = fifo_ready;
endmodule : lda_controller

//--- lda_detector.sv
`timescale 1ns/1ps
module lda_detector (
  input  wire logic                      CLK_SYS_I,
  input  wire logic                      NRST_I,
  input  wire logic                      CE_I,
  input  wire logic [lda_pkg::PIX_W-1:0] PIXEL_DATA_I,
  output logic                           PIXEL_READY_O,
  output logic                           INTEGRATING_O,
  output logic                           HIGH_GAIN_O,
  lda_if.det                             LINK
);
  typedef enum logic [1:0] {
    LDA_IDLE  = 2'b00,
    LDA_WAIT  = 2'b01,
    LDA_READ  = 2'b10
  } lda_state_type;

  lda_state_type             st_r;
  logic [1:0]                rst_s_r;
  logic [1:0]                start_s_r;
  logic [1:0]                role_s_r;
  logic [1:0]                gain_s_r;
  logic [1:0]                pitch_s_r;
  logic                      rst_d_r;
  logic                      start_d_r;
  logic [lda_pkg::CNT_W-1:0] cyc_r;
  logic [lda_pkg::CNT_W-1:0] pix_r;
  logic [lda_pkg::CNT_W-1:0] npix_r;
  logic [3:0]                rise_cnt_r;
  logic                      armed_r;
  logic                      fall_ev;
  logic                      rise_ev;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS_I) begin
    if (!NRST_I) begin
      rst_s_r   <= 2'b11;
      start_s_r <= 2'b11;
      role_s_r  <= 2'b11;
      gain_s_r  <= 2'b00;
      pitch_s_r <= 2'b00;
      rst_d_r   <= 1'b1;
      start_d_r <= 1'b1;
    end else if (CE_I) begin
      rst_s_r   <= {rst_s_r[0], LINK.line_reset_n};
      start_s_r <= {start_s_r[0], LINK.chain_start_in_n};
      role_s_r  <= {role_s_r[0], LINK.chain_role_select};
      gain_s_r  <= {gain_s_r[0], LINK.gain_select};
      pitch_s_r <= {pitch_s_r[0], LINK.pitch_select};
      rst_d_r   <= rst_s_r[1];
      start_d_r <= start_s_r[1];
    end
  end

  assign fall_ev = rst_d_r && !rst_s_r[1];
  assign rise_ev = !rst_d_r && rst_s_r[1];

  // ----------------------------------------------------------------
  // Gain and integration window
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS_I) begin
    if (!NRST_I) begin
      HIGH_GAIN_O   <= 1'b0;
      INTEGRATING_O <= 1'b0;
      rise_cnt_r    <= '0;
      armed_r       <= 1'b0;
    end else if (CE_I) begin
      HIGH_GAIN_O <= gain_s_r[1];
      if (rise_ev) begin
        armed_r    <= 1'b1;
        rise_cnt_r <= 4'h1;
      end else if (armed_r) begin
        rise_cnt_r <= rise_cnt_r + 4'h1;
        if (rise_cnt_r == 4'(lda_pkg::INT_START_EDGE)) begin
          INTEGRATING_O <= 1'b1;
          armed_r       <= 1'b0;
        end
      end
      if (st_r == LDA_WAIT && cyc_r == lda_pkg::CNT_W'(lda_pkg::INT_END_EDGE)) begin
        INTEGRATING_O <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Readout sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS_I) begin
    if (!NRST_I) begin
      st_r                   <= LDA_IDLE;
      cyc_r                  <= '0;
      pix_r                  <= '0;
      npix_r                 <= '0;
      LINK.pixel_strobe      <= 1'b0;
      LINK.scan_done_pulse_n <= 1'b1;
      LINK.video             <= '0;
      LINK.video_valid       <= 1'b0;
    end else if (CE_I) begin
      LINK.pixel_strobe      <= 1'b0;
      LINK.scan_done_pulse_n <= 1'b1;
      LINK.video_valid       <= 1'b0;
      unique case (st_r)
        LDA_IDLE: begin
          // Master starts on reset fall, slave on predecessor scan done
          if ((role_s_r[1] && fall_ev) || (!role_s_r[1] && start_d_r && !start_s_r[1])) begin
            st_r   <= LDA_WAIT;
            cyc_r  <= lda_pkg::CNT_W'(1);
            npix_r <= lda_pkg::pix_count(pitch_s_r[1]);
          end
        end
        LDA_WAIT: begin
          cyc_r <= cyc_r + 1'b1;
          if (cyc_r == lda_pkg::CNT_W'(lda_pkg::FIRST_PIX_EDGE - 1)) begin
            st_r  <= LDA_READ;
            cyc_r <= '0;
            pix_r <= '0;
          end
        end
        LDA_READ: begin
          cyc_r <= (cyc_r == lda_pkg::CNT_W'(lda_pkg::PIX_DIV - 1)) ? '0 : cyc_r + 1'b1;
          if (cyc_r == '0) begin
            LINK.video       <= PIXEL_DATA_I;
            LINK.video_valid <= 1'b1;
          end
          if (cyc_r == lda_pkg::CNT_W'(1)) begin
            LINK.pixel_strobe <= 1'b1;
          end
          if (pix_r == npix_r - 1'b1) begin
            LINK.scan_done_pulse_n <= 1'b0;
          end
          if (cyc_r == lda_pkg::CNT_W'(lda_pkg::PIX_DIV - 1)) begin
            pix_r <= pix_r + 1'b1;
            if (pix_r == npix_r - 1'b1) begin
              st_r <= LDA_IDLE;
            end
          end
        end
        default: st_r <= LDA_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!NRST_I) begin
      PIXEL_READY_O <= 1'b0;
    end else if (CE_I) begin
      // Raised one cycle early so the source can update before the next phase 0 sample
      PIXEL_READY_O <= (st_r == LDA_READ) && (cyc_r == lda_pkg::CNT_W'(lda_pkg::PIX_DIV - 2));
    end
  end
endmodule : lda_detector

//--- lda_fifo.sv
`timescale 1ns/1ps
module lda_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16
) (
  input  wire logic             clk_i,
  input  wire logic             nrst_i,
  input  wire logic             ce_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  output logic [WIDTH-1:0]      out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wp_r;
  logic [AW-1:0]    rp_r;
  logic [AW:0]      cnt_r;
  logic             wr;
  logic             rd;

  assign in_ready_o  = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_r != '0);
  assign out_data_o  = mem_r[rp_r];
  assign wr          = in_valid_i && in_ready_o;
  assign rd          = out_valid_o && out_ready_i;

  always_ff @(posedge clk_i) begin
    if (ce_i && wr) begin
      mem_r[wp_r] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else if (ce_i) begin
      if (wr) begin
        wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
      end
      if (rd) begin
        rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
      end
      if (wr && !rd) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (rd && !wr) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end
endmodule : lda_fifo

//--- lda_if.sv
`timescale 1ns/1ps
interface lda_if;
  logic                    line_reset_n;
  logic                    pixel_strobe;
  logic                    scan_done_pulse_n;
  logic [lda_pkg::PIX_W-1:0] video;
  logic                    video_valid;
  logic                    gain_select;
  logic                    pitch_select;
  logic                    chain_start_in_n;
  logic                    chain_role_select;

  modport det (
    input  line_reset_n, gain_select, pitch_select, chain_start_in_n, chain_role_select,
    output pixel_strobe, scan_done_pulse_n, video, video_valid
  );
  modport ctl (
    output line_reset_n, gain_select, pitch_select, chain_start_in_n, chain_role_select,
    input  pixel_strobe, scan_done_pulse_n, video, video_valid
  );
endinterface : lda_if

//--- lda_link_props.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Link checker
// ----------------------------------------------------------------
module lda_link_props #(
  parameter int HIGH_CYC = 400
) (
  input wire logic CLK_SYS_I,
  input wire logic NRST_I,
  input wire logic line_reset_n,
  input wire logic pixel_strobe,
  input wire logic scan_done_pulse_n,
  input wire logic video_valid,
  input wire logic chain_role_select
);
  logic        busy_r;
  logic        vid_r;
  int unsigned high_cnt_r;

  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!NRST_I);

  // Line open from reset fall until scan done returns high
  always_ff @(posedge CLK_SYS_I) begin
    if (!NRST_I) busy_r <= 1'b0;
    else if ($fell(line_reset_n)) busy_r <= 1'b1;
    else if ($rose(scan_done_pulse_n)) busy_r <= 1'b0;
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!NRST_I) vid_r <= 1'b0;
    else if (video_valid) vid_r <= 1'b1;
    else if ($rose(scan_done_pulse_n)) vid_r <= 1'b0;
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!NRST_I || !line_reset_n) high_cnt_r <= 0;
    else high_cnt_r <= high_cnt_r + 1;
  end

  sequence s_done_low;
    (!scan_done_pulse_n)[*4] ##1 scan_done_pulse_n;
  endsequence
  sequence s_last_pix;
    video_valid ##4 !video_valid;
  endsequence

  property p_done_pulse;
    $fell(scan_done_pulse_n) |-> s_done_low;
  endproperty
  property p_quiet_after;
    $rose(scan_done_pulse_n) |-> (!video_valid)[*8];
  endproperty
  property p_last_done;
    s_last_pix |-> ##[0:8] $rose(scan_done_pulse_n);
  endproperty
  property p_strobe_pulse;
    pixel_strobe |=> !pixel_strobe;
  endproperty
  property p_strobe_follows;
    video_valid |=> pixel_strobe;
  endproperty
  property p_cadence;
    video_valid |=> (!video_valid)[*3];
  endproperty
  property p_first_pix;
    $fell(line_reset_n) && chain_role_select |-> ##[16:26] video_valid;
  endproperty
  property p_reset_idle;
    disable iff (1'b0)
    !NRST_I |=> scan_done_pulse_n && !pixel_strobe && !video_valid && line_reset_n;
  endproperty
  property p_low_min;
    $fell(line_reset_n) |-> (!line_reset_n)[*8] ##1 (!line_reset_n)[*4];
  endproperty
  property p_high_min;
    $fell(line_reset_n) |-> high_cnt_r >= HIGH_CYC - 1;
  endproperty
  property p_next_line;
    $fell(line_reset_n) |-> !busy_r;
  endproperty
  property p_no_rise;
    $rose(line_reset_n) |-> !vid_r;
  endproperty

  a_done_pulse: assert property (p_done_pulse)
    else $error("scan done width wrong");
  a_quiet_after: assert property (p_quiet_after)
    else $error("pixel after scan done");
  a_last_done: assert property (p_last_done)
    else $error("pixel gap without scan done");
  a_strobe_pulse: assert property (p_strobe_pulse)
    else $error("strobe longer than one cycle");
  a_strobe_follows: assert property (p_strobe_follows)
    else $error("strobe missing after pixel");
  a_cadence: assert property (p_cadence)
    else $error("pixels closer than four cycles");
  a_first_pix: assert property (p_first_pix)
    else $error("first pixel late or missing");
  a_reset_idle: assert property (p_reset_idle)
    else $error("outputs active in reset");
  a_low_min: assert property (p_low_min)
    else $error("line reset low too short");
  a_high_min: assert property (p_high_min)
    else $error("line reset high too short");
  a_next_line: assert property (p_next_line)
    else $error("line restarted during readout");
  a_no_rise: assert property (p_no_rise)
    else $error("line reset rose during video");
endmodule : lda_link_props

//--- lda_pkg.sv
// Notes on behaviour
// - Pixel rate is clock divided by four
// - First pixel appears before 19th falling edge
// - Controller samples first pixel near 20th edge
// - Strobe high during first pixel sample window
// - Following pixels every fourth clock cycle
// - Reset never rises during pixel output
// - Line period at least 17 plus 4N
// - Scan done during last pixel output
// - Reset high at least 20 microseconds
// - Gain select high means high sensitivity
// - Integration spans edges 8 and 7 after reset
// - Slave start driven by previous scan done
// - Scan done is active low pulse
// - Pixel strobe is active high pulse
package lda_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ          = 20000000;
  localparam int PIX_DIV         = 4;
  localparam int FIRST_PIX_EDGE  = 19;
  localparam int SAMPLE_EDGE     = 20;
  localparam int LINE_OVERHEAD   = 17;
  localparam int RST_LOW_MIN_CYC = 12;
  localparam int INT_START_EDGE  = 8;
  localparam int INT_END_EDGE    = 7;
  localparam int RST_HIGH_MIN_US = 20;
  localparam int RST_HIGH_CYC    = (RST_HIGH_MIN_US * (CLK_HZ / 1000000));
  // ----------------------------------------------------------------
  // Array sizes
  // ----------------------------------------------------------------
  localparam int PIX_FINE        = 256;
  localparam int PIX_COARSE      = 128;
  localparam int PIX_W           = 12;
  localparam int CNT_W           = 16;

  function automatic logic [CNT_W-1:0] pix_count(input logic pitch_fine);
    pix_count = pitch_fine ? CNT_W'(PIX_FINE) : CNT_W'(PIX_COARSE);
  endfunction : pix_count
endpackage : lda_pkg

//--- tb.sv
`timescale 1ns/1ps
module tb;
  localparam int HI_CYC = 40;
  logic                      clk       = 1'b0;
  logic                      nrst      = 1'b0;
  logic                      enable    = 1'b0;
  logic                      gain      = 1'b0;
  logic                      pitch     = 1'b1;
  logic                      ready     = 1'b1;
  logic                      stall     = 1'b0;
  logic                      ce        = 1'b1;
  logic                      done_q    = 1'b1;
  logic [lda_pkg::PIX_W-1:0] pix_in    = '0;
  logic [lda_pkg::PIX_W-1:0] nxt_pix;
  logic [lda_pkg::PIX_W-1:0] pix_out;
  logic [lda_pkg::PIX_W-1:0] exp_q[$];
  logic                      pix_take, integ, hgain, pix_valid, line_done, done_seen;
  int                        seed        = 99;
  int                        error_cnt   = 0;
  int                        checks_done = 0;
  int                        pix_cnt     = 0;

  always #25 clk = ~clk;

  lda_if lda_if_i ();
  lda_detector lda_detector_i (.CLK_SYS_I(clk), .NRST_I(nrst), .CE_I(ce), .PIXEL_DATA_I(pix_in),
    .PIXEL_READY_O(pix_take), .INTEGRATING_O(integ), .HIGH_GAIN_O(hgain), .LINK(lda_if_i));
  lda_controller #(.HIGH_CYC(HI_CYC), .LOW_CYC(16)) lda_controller_i (.CLK_SYS_I(clk), .NRST_I(nrst),
    .CE_I(ce), .ENABLE_I(enable), .GAIN_HIGH_I(gain), .PITCH_FINE_I(pitch), .SLAVE_I(1'b0),
    .START_IN_N_I(1'b1), .PIX_DATA_O(pix_out), .PIX_VALID_O(pix_valid), .PIX_READY_I(ready),
    .LINE_DONE_O(line_done), .LINK(lda_if_i));
  lda_link_props #(.HIGH_CYC(HI_CYC)) lda_link_props_i (.CLK_SYS_I(clk), .NRST_I(nrst),
    .line_reset_n(lda_if_i.line_reset_n), .pixel_strobe(lda_if_i.pixel_strobe),
    .scan_done_pulse_n(lda_if_i.scan_done_pulse_n), .video_valid(lda_if_i.video_valid),
    .chain_role_select(lda_if_i.chain_role_select));

  task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : cmp

  task automatic stop_test();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : stop_test

  // ----------------------------------------------------------------
  // Pixel source: new value after each pixel period, noted in order
  // ----------------------------------------------------------------
  initial exp_q.push_back('0);
  always @(posedge clk) begin
    if (pix_take === 1'b1) begin
      nxt_pix = lda_pkg::PIX_W'($random(seed));
      pix_in <= nxt_pix;
      exp_q.push_back(nxt_pix);
    end
  end

  always @(posedge clk) ready <= !stall && ($random(seed) % 4 != 0);

  // ----------------------------------------------------------------
  // Sink and wire watchers
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (pix_valid === 1'b1 && ready === 1'b1)
      cmp("pixel", (exp_q.size() != 0) ? exp_q.pop_front() : 'x, pix_out);
  end

  always @(posedge clk) begin
    done_q <= lda_if_i.scan_done_pulse_n;
    if (lda_if_i.line_reset_n === 1'b0) pix_cnt <= 0;
    else if (lda_if_i.video_valid === 1'b1) pix_cnt <= pix_cnt + 1;
  end
  assign done_seen = (done_q === 1'b0) && (lda_if_i.scan_done_pulse_n === 1'b1);

  task automatic wait_done();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
      if (n > 3000) begin
        cmp("timeout", 16'h0000, 16'h0001);
        stop_test();
      end
    end while (done_seen !== 1'b1);
  endtask : wait_done

  // ----------------------------------------------------------------
  // Main sequence: every gain and pitch setting, one stall
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    enable <= 1'b1;
    for (int m = 0; m < 4; m++) begin
      gain <= m[0];
      pitch <= !m[1];
      repeat (5) @(posedge clk);
      #1;
      cmp("gain", 16'(gain), 16'(hgain));
      wait_done();
      if (m == 2) begin
        repeat (90) @(posedge clk);
        stall <= 1'b1;
        repeat (40) @(posedge clk);
        stall <= 1'b0;
      end
      wait_done();
      cmp("integ", 16'h0001, 16'(integ));
      cmp("count", pitch ? 16'(lda_pkg::PIX_FINE) : 16'(lda_pkg::PIX_COARSE), 16'(pix_cnt));
    end
    repeat (40) @(posedge clk);
    stop_test();
  end
endmodule : tb
